// ==== common/burst_pkg.sv ====
// constants, types and register map of the burst capture handshake
// assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data
package burst_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
    localparam logic [7:0] ADDR_CAPS = 8'h14;
    localparam logic [7:0] ADDR_STORED = 8'h18;
    // ctrl fields
    localparam int CTRL_PIPE = 0;
    localparam int CTRL_PARALLEL = 1;
    localparam int CTRL_LOGGING = 2;
    localparam int CTRL_LIVE = 3;
    localparam int CTRL_MULTI_BLK = 4;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    // irq bits
    localparam int IRQ_PORT_ERR = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_ABORT = 3;
    localparam int IRQ_W = 4;
    // timeout default, 1 ms expressed in cycles
    localparam int TIMEOUT_US = 1000;
    localparam logic [31:0] TIMEOUT_RESET = 32'(TIMEOUT_US * CLK_MHZ);
    localparam logic [7:0] CAPS_RESET = 8'h02;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_CAPTURE = 3'b011,
        ST_MEASURE = 3'b010,
        ST_WAIT = 3'b110,
        ST_POST = 3'b111,
        ST_DISPLAY = 3'b101
    } seq_e;

    typedef struct packed {
        logic capture_done;
        logic measure_done;
        logic setup_done;
        logic post_done;
    } engine_done_s;

    typedef struct packed {
        logic start_setup;
        logic start_capture;
        logic start_measure;
        logic start_post;
        logic start_display;
        logic store_image;
    } engine_cmd_s;
endpackage : burst_pkg

// ==== rtl/burst_capture_handshake.sv ====
// burst capture handshake sequencer with AXI4-Lite registers
// assumes trigger and engine done strobes are synchronous to aclk
//
// Overview of operation
// R1: controller waits ready high, busy low first
// R2: accepted trigger drops ready, raises busy, captures
// R3: controller drops trigger after seeing handshake
// R4: non-pipelined serial mode measures right after capture
// R5: ready returns only after whole task block
// R6: next trigger drops ready, applies settings, captures
// R7: post processing, busy falls, then display
// R8: trigger while not ready is ignored, error raised
// R9: no trigger within timeout fails unit, ends
// R10: multiple blocks or live view ends flow
// R11: pipelined mode never reapplies camera settings
// R12: per-capture mode sets parameters after each image
// R13: logging on stores every captured image
// R14: task results valid only after burst done
// R15: pipelined mode raises ready after image input
// R16: idle holds ready high, busy and error low
// R17: timeout counter restarts at ready, stops at trigger
module burst_capture_handshake
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger,
    output logic ready,
    output logic busy,
    output logic port_error,
    output logic unit_fail,
    output logic results_valid,
    input wire burst_pkg::engine_done_s done,
    output burst_pkg::engine_cmd_s cmd,
    output logic irq
);
    import burst_pkg::*;

    // ========================================================
    // sequencer
    seq_e state, next_state;
    logic trig_q, next_trig_q;
    logic ready_r, next_ready;
    logic busy_r, next_busy;
    logic err_r, next_err;
    logic fail_r, next_fail;
    logic valid_r, next_valid;
    logic meas_pend, next_meas_pend;
    logic [7:0] cap_idx, next_cap_idx;
    logic [7:0] stored, next_stored;
    logic [31:0] tcount, next_tcount;
    engine_cmd_s cmd_r, next_cmd;
    logic [31:0] ctrl, timeout, caps_total;
    logic [IRQ_W-1:0] ev;
    logic trig_rise;
    logic pipe;

    assign trig_rise = trigger && !trig_q;
    assign pipe = ctrl[CTRL_PIPE];

    always_comb
    begin
        next_state = state;
        next_trig_q = trigger;
        next_ready = ready_r;
        next_busy = busy_r;
        next_err = 1'b0;
        next_fail = fail_r;
        next_valid = valid_r;
        next_meas_pend = meas_pend;
        next_cap_idx = cap_idx;
        next_stored = stored;
        next_tcount = tcount;
        next_cmd = '0;
        ev = '0;
        // waiting for trigger counts, ready restarts it
        if (ready_r && state != ST_IDLE && !trig_rise)   // [R17]
            next_tcount = tcount + 32'h1;
        if (trig_rise && !ready_r)
        begin
            next_err = 1'b1;   // [R8]
            ev[IRQ_PORT_ERR] = 1'b1;
        end
        unique case (state)
            ST_IDLE:
            begin
                next_ready = 1'b1;   // [R16]
                next_busy = 1'b0;
                if (trig_rise)
                begin
                    next_fail = 1'b0;
                    next_valid = 1'b0;
                    next_cap_idx = 8'h00;
                    next_stored = 8'h00;
                    next_tcount = 32'h0;
                    if (ctrl[CTRL_MULTI_BLK] || ctrl[CTRL_LIVE])
                    begin
                        ev[IRQ_ABORT] = 1'b1;   // [R10]
                    end
                    else
                    begin
                        next_ready = 1'b0;   // [R2]
                        next_busy = 1'b1;
                        next_cmd.start_capture = 1'b1;
                        next_state = ST_CAPTURE;
                    end
                end
            end
            ST_SETUP:
            begin
                // settings for the next image lengthen the interval
                if (done.setup_done)   // [R12]
                begin
                    next_cmd.start_capture = 1'b1;
                    next_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE:
            begin
                if (done.capture_done)
                begin
                    if (ctrl[CTRL_LOGGING] || cap_idx == 8'h00)
                    begin
                        next_cmd.store_image = 1'b1;   // [R13]
                        next_stored = stored + 8'h01;
                    end
                    next_cap_idx = cap_idx + 8'h01;
                    next_cmd.start_measure = 1'b1;
                    next_meas_pend = 1'b1;
                    if (pipe)
                    begin
                        next_ready = 1'b1;   // [R15]
                        next_tcount = 32'h0;
                        next_state = ST_WAIT;
                    end
                    else
                    begin
                        next_state = ST_MEASURE;   // [R4]
                    end
                end
            end
            ST_MEASURE:
            begin
                if (done.measure_done)
                begin
                    next_meas_pend = 1'b0;
                    if (cap_idx >= caps_total[7:0])
                    begin
                        next_cmd.start_post = 1'b1;
                        next_state = ST_POST;
                    end
                    else
                    begin
                        next_ready = 1'b1;   // [R5]
                        next_tcount = 32'h0;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (done.measure_done)
                    next_meas_pend = 1'b0;
                if (pipe && cap_idx >= caps_total[7:0])
                begin
                    next_ready = 1'b0;
                    if (!meas_pend || done.measure_done)
                    begin
                        next_cmd.start_post = 1'b1;
                        next_state = ST_POST;
                    end
                end
                else if (trig_rise && ready_r)
                begin
                    next_ready = 1'b0;   // [R6]
                    if (pipe)
                    begin
                        next_cmd.start_capture = 1'b1;   // [R11]
                        next_state = ST_CAPTURE;
                    end
                    else
                    begin
                        next_cmd.start_setup = 1'b1;   // [R12]
                        next_state = ST_SETUP;
                    end
                end
                else if (tcount >= timeout)
                begin
                    next_fail = 1'b1;   // [R9]
                    ev[IRQ_TIMEOUT] = 1'b1;
                    next_ready = 1'b1;
                    next_busy = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            ST_POST:
            begin
                if (done.post_done)
                begin
                    next_busy = 1'b0;   // [R7]
                    next_valid = 1'b1;   // [R14]
                    next_cmd.start_display = 1'b1;
                    ev[IRQ_DONE] = 1'b1;
                    next_state = ST_DISPLAY;
                end
            end
            ST_DISPLAY:
            begin
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            trig_q <= 1'b0;
            ready_r <= 1'b1;
            busy_r <= 1'b0;
            err_r <= 1'b0;
            fail_r <= 1'b0;
            valid_r <= 1'b0;
            meas_pend <= 1'b0;
            cap_idx <= 8'h00;
            stored <= 8'h00;
            tcount <= 32'h0;
            cmd_r <= '0;
        end
        else
        begin
            state <= next_state;
            trig_q <= next_trig_q;
            ready_r <= next_ready;
            busy_r <= next_busy;
            err_r <= next_err;
            fail_r <= next_fail;
            valid_r <= next_valid;
            meas_pend <= next_meas_pend;
            cap_idx <= next_cap_idx;
            stored <= next_stored;
            tcount <= next_tcount;
            cmd_r <= next_cmd;
        end
    end

    assign ready = ready_r;
    assign busy = busy_r;
    assign port_error = err_r;
    assign unit_fail = fail_r;
    assign results_valid = valid_r;
    assign cmd = cmd_r;

    // ========================================================
    // AXI4-Lite slave
    logic aw_ok, w_ok, next_aw_ok, next_w_ok, bv, next_bv, rv, next_rv;
    logic [7:0] awa, next_awa;
    logic [31:0] wd, next_wd, rd, next_rd;
    logic [1:0] br, next_br, rr, next_rr;
    logic [IRQ_W-1:0] istat, next_istat, imask, next_imask;
    logic [31:0] next_ctrl, next_timeout, next_caps;
    logic irq_r, next_irq;
    logic do_wr;

    assign do_wr = aw_ok && w_ok && !bv;

    always_comb
    begin
        next_aw_ok = aw_ok || (s_axi_awvalid && !aw_ok);
        next_awa = (s_axi_awvalid && !aw_ok) ? s_axi_awaddr : awa;
        next_w_ok = w_ok || (s_axi_wvalid && !w_ok);
        next_wd = (s_axi_wvalid && !w_ok) ? s_axi_wdata : wd;
        next_bv = bv && !s_axi_bready;
        next_br = br;
        next_ctrl = ctrl;
        next_timeout = timeout;
        next_caps = caps_total;
        next_imask = imask;
        // set wins over write-one-to-clear
        next_istat = istat;
        if (do_wr)
        begin
            next_aw_ok = 1'b0;
            next_w_ok = 1'b0;
            next_bv = 1'b1;
            next_br = RESP_OKAY;
            unique case (awa)
                ADDR_CTRL: next_ctrl = wd;
                ADDR_TIMEOUT: next_timeout = wd;
                ADDR_CAPS: next_caps = wd;
                ADDR_IRQ_MASK: next_imask = wd[IRQ_W-1:0];
                ADDR_IRQ_STAT: next_istat = istat & ~wd[IRQ_W-1:0];
                ADDR_STATUS, ADDR_STORED: next_br = RESP_OKAY;
                default: next_br = RESP_SLVERR;
            endcase
        end
        next_istat = next_istat | ev;
        next_irq = |(next_istat & next_imask);
        next_rv = rv && !s_axi_rready;
        next_rd = rd;
        next_rr = rr;
        if (s_axi_arvalid && !rv)
        begin
            next_rv = 1'b1;
            next_rr = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL: next_rd = ctrl;
                ADDR_STATUS: next_rd = {24'h0, cap_idx[3:0], valid_r,
                                        fail_r, busy_r, ready_r};
                ADDR_IRQ_STAT: next_rd = {28'h0, istat};
                ADDR_IRQ_MASK: next_rd = {28'h0, imask};
                ADDR_TIMEOUT: next_rd = timeout;
                ADDR_CAPS: next_rd = caps_total;
                ADDR_STORED: next_rd = {24'h0, stored};
                default:
                begin
                    next_rd = 32'h0;
                    next_rr = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            awa <= 8'h00;
            wd <= 32'h0;
            bv <= 1'b0;
            br <= RESP_OKAY;
            rv <= 1'b0;
            rd <= 32'h0;
            rr <= RESP_OKAY;
            ctrl <= CTRL_RESET;
            timeout <= TIMEOUT_RESET;
            caps_total <= {24'h0, CAPS_RESET};
            istat <= '0;
            imask <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            aw_ok <= next_aw_ok;
            w_ok <= next_w_ok;
            awa <= next_awa;
            wd <= next_wd;
            bv <= next_bv;
            br <= next_br;
            rv <= next_rv;
            rd <= next_rd;
            rr <= next_rr;
            ctrl <= next_ctrl;
            timeout <= next_timeout;
            caps_total <= next_caps;
            istat <= next_istat;
            imask <= next_imask;
            irq_r <= next_irq;
        end
    end

    assign s_axi_awready = !aw_ok;
    assign s_axi_wready = !w_ok;
    assign s_axi_bvalid = bv;
    assign s_axi_bresp = br;
    assign s_axi_arready = !rv;
    assign s_axi_rvalid = rv;
    assign s_axi_rdata = rd;
    assign s_axi_rresp = rr;
    assign irq = irq_r;

    // ========================================================
    // assertions
    a_trig_accept: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_IDLE && trig_rise && !ctrl[CTRL_MULTI_BLK]
        && !ctrl[CTRL_LIVE] |=> !ready && busy) // [R2]
        else $error("trigger not accepted");
    a_serial_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_MEASURE |-> !ready) // [R4]
        else $error("ready high during serial measure");
    a_block_done: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_MEASURE && done.measure_done
        && cap_idx < caps_total[7:0] |=> ready) // [R5]
        else $error("ready not back after block");
    a_next_trig: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && trig_rise && ready && !pipe
        |=> !ready && cmd.start_setup) // [R6]
        else $error("next capture mishandled");
    a_busy_fall: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_POST && done.post_done
        |=> !busy && cmd.start_display && results_valid) // [R7]
        else $error("burst end mishandled");
    a_port_err: assert property (@(posedge aclk) disable iff (!aresetn)
        trig_rise && !ready |=> port_error) // [R8]
        else $error("error not raised");
    a_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && !pipe && !trig_rise && tcount >= timeout
        |=> unit_fail && state == ST_IDLE) // [R9]
        else $error("timeout not judged");
    a_abort: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_IDLE && trig_rise && ctrl[CTRL_LIVE]
        |=> state == ST_IDLE && ready) // [R10]
        else $error("live view did not end");
    a_pipe_nosetup: assert property (@(posedge aclk) disable iff (!aresetn)
        pipe && $stable(pipe) |-> !cmd.start_setup) // [R11]
        else $error("setup in pipelined mode");
    a_pipe_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_CAPTURE && pipe && done.capture_done |=> ready) // [R15]
        else $error("pipelined ready late");
    a_idle_out: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_IDLE && $past(state) == ST_IDLE && !$past(trig_rise)
        |-> ready && !busy) // [R16]
        else $error("idle outputs wrong");
    a_log_all: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_CAPTURE && done.capture_done && ctrl[CTRL_LOGGING]
        |=> cmd.store_image) // [R13]
        else $error("image not stored");
    c_serial: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_MEASURE ##[1:50] state == ST_WAIT);
    c_done: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_POST ##1 state == ST_DISPLAY);
    c_err: cover property (@(posedge aclk) disable iff (!aresetn)
        port_error);
    c_fail: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(unit_fail));
endmodule : burst_capture_handshake

// ==== testbench/step_controller_model.sv ====
// far side: step controller and a stub of the capture engines
// assumes one aclk domain and a synchronous active-low reset
module step_controller_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic first,
    input wire logic rude,
    input var int lat,
    input var int meas_lat,
    input wire logic ready,
    input wire logic busy,
    input wire burst_pkg::engine_cmd_s cmd,
    output burst_pkg::engine_done_s done,
    output logic trigger,
    output logic pending
);
    timeunit 1ns;
    timeprecision 1ps;
    import burst_pkg::*;
    typedef enum logic [1:0] {C_IDLE, C_WAIT, C_HOLD} ctl_e;
    ctl_e cs;
    logic [3:0] st;
    logic [3:0] d;
    int cnt [4];
    // ============================================================
    // controller: rude skips the handshake checks on purpose
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cs <= C_IDLE;
            trigger <= 1'b0;
        end
        else if (cs == C_IDLE && go)
            cs <= C_WAIT;
        else if (cs == C_WAIT && (rude || (ready && !(first && busy))))
        begin
            trigger <= 1'b1;
            cs <= C_HOLD;
        end
        else if (cs == C_HOLD && (rude || (!ready && busy)))
        begin
            trigger <= 1'b0;
            cs <= C_IDLE;
        end
    end
    assign pending = (cs != C_IDLE);
    // ============================================================
    // engines: one countdown each, a restart drops the older job
    assign st = {cmd.start_capture, cmd.start_measure, cmd.start_setup,
                 cmd.start_post};
    assign done = d;
    always @(posedge aclk)
    begin
        for (int k = 0; k < 4; k++)
        begin
            d[k] <= aresetn && cnt[k] == 1;
            if (!aresetn)
                cnt[k] <= 0;
            else if (st[k])
                cnt[k] <= (k == 2) ? meas_lat : lat;
            else if (cnt[k] != 0)
                cnt[k] <= cnt[k] - 1;
        end
    end
endmodule : step_controller_model

// ==== testbench/burst_capture_handshake_tb_top.sv ====
// self-checking bench for the burst capture handshake
// assumes the package in common/ and the partner model in testbench/
module burst_capture_handshake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import burst_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, v;
    logic trigger, ready, busy, port_error, unit_fail, results_valid, irq;
    logic pending, meas_on = 1'b0, disp_busy;
    logic go = 1'b0, first = 1'b0, rude = 1'b0;
    int lat = 3, meas_lat = 10;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    int n_setup, n_meas, n_perr, r_meas;
    engine_done_s done;
    engine_cmd_s cmd;

    burst_capture_handshake burst_capture_handshake_i
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trigger, .ready, .busy,
        .port_error, .unit_fail, .results_valid, .done, .cmd, .irq
    );
    step_controller_model step_controller_model_i
    (
        .aclk, .aresetn, .go, .first, .rude, .lat, .meas_lat, .ready,
        .busy, .cmd, .done, .trigger, .pending
    );

    initial
        forever #2 aclk = ~aclk;
    // ============================================================
    // monitors and hang guard
    always @(posedge aclk)
    begin
        if (meas_on && ready)
            r_meas++;
        if (cmd.start_measure)
            meas_on = 1'b1;
        if (done.measure_done)
            meas_on = 1'b0;
        if (cmd.start_setup)
            n_setup++;
        if (cmd.start_measure)
            n_meas++;
        if (port_error)
            n_perr++;
        if (cmd.start_display)
            disp_busy = busy;
    end
    initial
    begin
        forever
        begin
            @(posedge aclk);
            cycles++;
            if (cycles == 20000)
            begin
                n_mismatch++;
                final_report();
            end
        end
    end
    // ============================================================
    // tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid)
            @(posedge aclk);
        check("bresp", s_axi_bresp, RESP_OKAY);
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    task automatic step(input logic f, input logic rd);
        first <= f;
        rude <= rd;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        while (pending)
            @(posedge aclk);
    endtask : step
    task automatic finish_flow();
        while (busy !== 1'b0)
            @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask : finish_flow
    task automatic clear_irq();
        axi_write(ADDR_IRQ_STAT, 32'h0000000F);
        repeat (2) @(posedge aclk);
    endtask : clear_irq
    // ============================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("ready idle", ready, 1);
        check("busy idle", {busy, port_error, irq}, 0);
        axi_read(ADDR_CTRL, v, r);
        check("ctrl", v, CTRL_RESET);
        axi_read(ADDR_TIMEOUT, v, r);
        check("timeout", v, TIMEOUT_RESET);
        axi_read(ADDR_CAPS, v, r);
        check("caps", v, {24'h0, CAPS_RESET});
        axi_read(8'h40, v, r);
        check("unmapped", v, 0);
        check("unmapped resp", r, RESP_SLVERR);
        axi_write(ADDR_STATUS, 32'h000000FF);
        axi_read(ADDR_STATUS, v, r);
        check("status", v[3:0], 4'h1);
        axi_write(ADDR_TIMEOUT, 32'd200);
        axi_write(ADDR_IRQ_MASK, 32'h0000000F);
        // m 0: per-capture serial, m 1: pipelined with logging
        for (int m = 0; m < 2; m++)
        begin
            n_setup = 0;
            n_meas = 0;
            r_meas = 0;
            disp_busy = 1'bx;
            axi_write(ADDR_CTRL, m ? 32'h00000005 : 32'h0);
            meas_lat <= 12;
            step(1'b1, 1'b0);
            check("busy on", {ready, busy}, 2'b01);
            check("valid mid", results_valid, 0);
            // waiting out the measure keeps the engine stub single-job
            while (n_meas == 0 || meas_on)
                @(posedge aclk);
            step(1'b0, 1'b0);
            finish_flow();
            axi_read(ADDR_STORED, v, r);
            check("stored", v, m + 1);
            check("setups", n_setup, m ? 0 : 1);
            check("measures", n_meas, 2);
            check("ready in measure", r_meas != 0, m);
            check("busy at display", disp_busy, 0);
            check("valid end", results_valid, 1);
            check("ready back", ready, 1);
            check("irq done", irq, 1);
            axi_read(ADDR_IRQ_STAT, v, r);
            check("done bit", v[IRQ_DONE], 1);
            clear_irq();
            check("irq clear", irq, 0);
        end
        axi_write(ADDR_CTRL, 32'h0);
        axi_write(ADDR_IRQ_MASK, 32'h1 << IRQ_DONE);
        n_perr = 0;
        meas_lat <= 40;
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        repeat (3) @(posedge aclk);
        check("port error", n_perr, 1);
        check("busy kept", busy, 1);
        check("irq masked", irq, 0);
        axi_read(ADDR_IRQ_STAT, v, r);
        check("err bit", v[IRQ_PORT_ERR], 1);
        step(1'b0, 1'b0);
        finish_flow();
        check("irq unmasked", irq, 1);
        clear_irq();
        axi_write(ADDR_TIMEOUT, 32'd20);
        step(1'b1, 1'b0);
        while (ready !== 1'b1)
            @(posedge aclk);
        repeat (15) @(posedge aclk);
        check("early fail", {unit_fail, busy}, 2'b01);
        repeat (10) @(posedge aclk);
        check("unit fail", {unit_fail, busy}, 2'b10);
        axi_read(ADDR_IRQ_STAT, v, r);
        check("timeout bit", v[IRQ_TIMEOUT], 1);
        clear_irq();
        for (int k = CTRL_LIVE; k <= CTRL_MULTI_BLK; k++)
        begin
            axi_write(ADDR_CTRL, 32'h1 << k);
            step(1'b1, 1'b1);
            repeat (3) @(posedge aclk);
            check("no start", {ready, busy}, 2'b10);
            axi_read(ADDR_IRQ_STAT, v, r);
            check("abort bit", v[IRQ_ABORT], 1);
            clear_irq();
        end
        final_report();
    end
endmodule : burst_capture_handshake_tb_top
